// ===== hdl/epv_exception_unit.sv
`timescale 1ns/1ps
`default_nettype none
module epv_exception_unit (
    input wire logic clock,
    input wire logic rst,
    input wire logic [11:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic boundary,
    input wire epv_pkg::epv_event_t ev,
    input wire logic [31:0] cur_ip,
    input wire logic [31:0] next_ip,
    input wire logic acc_valid,
    input wire logic [31:0] acc_addr,
    input wire logic mgmt_mode_request,
    input wire logic maskable_request,
    output logic inta_req,
    input wire logic inta_ack,
    input wire logic [7:0] inta_vector,
    input wire logic handler_enter,
    input wire logic gate_is_maskable_request,
    input wire logic handler_return,
    output logic busy,
    output logic res_valid,
    output epv_pkg::epv_result_t res
);
    import epv_pkg::*;

    // ****************************************
    // levels and state
    // ****************************************
    localparam int IX_SMI = 0;
    localparam int IX_DBL = 1;
    localparam int IX_PREV_DBG = 2;
    localparam int IX_SWINT = 3;
    localparam int IX_NEXT_DBG = 4;
    localparam int IX_NMI = 5;
    localparam int IX_MASKABLE_REQUEST = 6;
    localparam int IX_FETCH = 7;
    localparam int IX_DECODE = 8;
    localparam int IX_DNA_WAIT = 9;
    localparam int IX_DNA_ESC = 10;
    localparam int IX_FPU = 11;
    localparam int IX_SEG = 12;
    localparam int IX_PAGE = 13;
    localparam int IX_ALIGN = 14;
    localparam int IX_EXEC = 15;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACK = 3'b010,
        ST_HOLD = 3'b100
    } epv_state_t;

    epv_state_t state_q;
    logic [31:0] flags_q;
    logic [4:0] ctl_q;
    logic [31:0] base_q;
    logic [15:0] limit_q;
    logic [4*32-1:0] dbg_q;
    logic [7:0] config_ctrl_seven_q;
    logic nmi_pend_q;
    logic nmi_active_q;
    logic data_bp_q;
    logic ack_q;
    logic res_valid_q;
    epv_result_t res_q;
    logic [NLVL-1:0] lvl_req;
    logic [NLVL-1:0] win;
    logic [NLVL-1:0] win_q;
    logic bp_hit;
    logic wr_fire;
    logic rd_fire;
    logic config_ctrl_seven_nmi_wr;
    logic decide;
    epv_result_t pick;

    // ****************************************
    // register bus
    // ****************************************
    // one wait state on every access; the answer lands at the second edge
    assign waitrequest = (read || write) && !ack_q;
    assign wr_fire = write && ack_q;
    assign rd_fire = read && ack_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (read || write) && !ack_q;
        end
    end

    function automatic logic [31:0] rd_mux(input logic [11:0] a);
        case (a)
            OFS_FLAGS: rd_mux = flags_q;
            OFS_CTL: rd_mux = {27'h0, ctl_q};
            OFS_BASE: rd_mux = base_q;
            OFS_LIMIT: rd_mux = {16'h0, limit_q};
            OFS_DBG0: rd_mux = dbg_q[31:0];
            OFS_DBG0 + 12'h004: rd_mux = dbg_q[63:32];
            OFS_DBG0 + 12'h008: rd_mux = dbg_q[95:64];
            OFS_DBG0 + 12'h00C: rd_mux = dbg_q[127:96];
            OFS_CONFIG_CTRL_SEVEN: rd_mux = {24'h0, config_ctrl_seven_q};
            OFS_STATUS: rd_mux = {21'h0, nmi_active_q, nmi_pend_q,
                                  state_q != ST_IDLE, res_q.vector};
            default: rd_mux = 32'h00000000;
        endcase
    endfunction

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            readdata <= 32'h00000000;
        end else if (read && !ack_q) begin
            readdata <= rd_mux(address);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctl_q <= 5'h00;
            base_q <= BASE_RST;
            limit_q <= LIMIT_RST;
            dbg_q <= '0;
            config_ctrl_seven_q <= 8'h00;
        end else if (wr_fire) begin
            case (address)
                OFS_CTL: ctl_q <= writedata[4:0];
                OFS_BASE: base_q <= writedata;
                OFS_LIMIT: limit_q <= writedata[15:0];
                OFS_DBG0: dbg_q[31:0] <= writedata;
                OFS_DBG0 + 12'h004: dbg_q[63:32] <= writedata;
                OFS_DBG0 + 12'h008: dbg_q[95:64] <= writedata;
                OFS_DBG0 + 12'h00C: dbg_q[127:96] <= writedata;
                OFS_CONFIG_CTRL_SEVEN: config_ctrl_seven_q <= writedata[7:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // flags word
    // ****************************************
    // hardware clearing of the enable flag wins over a bus write that lands in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flags_q <= FLAGS_RST;
        end else if (handler_enter && gate_is_maskable_request) begin
            flags_q[FLAG_IF] <= 1'b0;
        end else if (wr_fire && address == OFS_FLAGS) begin
            flags_q <= writedata;
        end
    end

    // ****************************************
    // nonmaskable tracking
    // ****************************************
    assign config_ctrl_seven_nmi_wr = wr_fire && address == OFS_CONFIG_CTRL_SEVEN && writedata[CONFIG_CTRL_SEVEN_NMI_BIT];
    assign decide = state_q == ST_IDLE && boundary;

    // only one further request is remembered while a handler runs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            nmi_pend_q <= 1'b0;
        end else if (config_ctrl_seven_nmi_wr) begin
            nmi_pend_q <= 1'b1;
        end else if (decide && win[IX_NMI]) begin
            nmi_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            nmi_active_q <= 1'b0;
        end else if (decide && win[IX_NMI]) begin
            nmi_active_q <= 1'b1;
        end else if (handler_return) begin
            nmi_active_q <= 1'b0;
        end
    end

    // ****************************************
    // data breakpoints
    // ****************************************
    epv_dbg_match #(
        .NREG(4)
    ) u_match (
        .addr_regs(dbg_q),
        .acc_valid(acc_valid),
        .acc_addr(acc_addr),
        .hit(bp_hit)
    );

    // a hit during the boundary cycle is kept for the next instruction
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            data_bp_q <= 1'b0;
        end else if (bp_hit) begin
            data_bp_q <= 1'b1;
        end else if (decide && ev.instr_done) begin
            data_bp_q <= 1'b0;
        end
    end

    // ****************************************
    // arbitration
    // ****************************************
    always_comb begin
        lvl_req = '0;
        lvl_req[IX_SMI] = mgmt_mode_request;
        lvl_req[IX_DBL] = ev.deliver_fault;
        lvl_req[IX_PREV_DBG] = ev.instr_done && (flags_q[FLAG_TF] || data_bp_q);
        lvl_req[IX_SWINT] = ev.instr_done && (ev.swint || ev.brk_op || ev.ovf_trap);
        lvl_req[IX_NEXT_DBG] = ev.instr_bp;
        lvl_req[IX_NMI] = nmi_pend_q && !nmi_active_q;
        lvl_req[IX_MASKABLE_REQUEST] = maskable_request && flags_q[FLAG_IF];
        lvl_req[IX_FETCH] = ev.fetch_fault;
        lvl_req[IX_DECODE] = ev.decode_fault;
        lvl_req[IX_DNA_WAIT] = ev.is_wait && ctl_q[CTL_TS] && ctl_q[CTL_MP];
        lvl_req[IX_DNA_ESC] = ev.is_esc && (ctl_q[CTL_EM] || ctl_q[CTL_TS]);
        lvl_req[IX_FPU] = ev.fpu_unmasked && ctl_q[CTL_NE];
        lvl_req[IX_SEG] = ev.seg_fault;
        lvl_req[IX_PAGE] = ev.page_fault;
        lvl_req[IX_ALIGN] = ev.align_fault;
        lvl_req[IX_EXEC] = ev.exec_fault;
    end

    epv_prio_pick #(
        .N(NLVL)
    ) u_pick (
        .req(lvl_req),
        .grant(win)
    );

    function automatic logic [7:0] sw_vec(input epv_event_t e);
        if (e.brk_op) begin
            sw_vec = VEC_BRK;
        end else if (e.swint) begin
            sw_vec = e.swint_vec;
        end else begin
            sw_vec = VEC_BRK + 8'h01;
        end
    endfunction

    function automatic logic err_vec(input logic [7:0] v, input logic pe);
        err_vec = pe && (v == VEC_DOUBLE || v == VEC_ALIGN || v == VEC_PAGE
                         || (v >= 8'h0A && v <= 8'h0D));
    endfunction

    // table entry location; reaching past the limit sets limit_err and keeps the vector
    function automatic epv_result_t finish(input epv_result_t r, input logic pe,
                                           input logic [31:0] b, input logic [15:0] l);
        logic [31:0] ofs;
        logic [31:0] last;
        ofs = pe ? {21'h0, r.vector, 3'h0} : {22'h0, r.vector, 2'h0};
        r.entry_size = pe ? SIZE_PROT : SIZE_REAL;
        last = ofs + {28'h0, r.entry_size} - 32'h00000001;
        r.limit_err = r.cls != CL_SMM && last > {16'h0, l};
        r.entry_addr = b + ofs;
        r.push_err = r.cls != CL_SMM && err_vec(r.vector, pe);
        finish = r;
    endfunction

    always_comb begin
        pick = '0;
        pick.save_flags = flags_q;
        pick.save_ip = next_ip;
        pick.cls = CL_FAULT;
        pick.restart = 1'b1;
        case (1'b1)
            win[IX_SMI]: begin
                pick.cls = CL_SMM;
                pick.restart = 1'b0;
            end
            win[IX_DBL]: begin
                pick.vector = VEC_DOUBLE;
                pick.cls = CL_ABORT;
                pick.restart = 1'b0;
                pick.save_ip = cur_ip;
            end
            win[IX_PREV_DBG]: begin
                pick.vector = VEC_DEBUG;
                pick.cls = CL_TRAP;
            end
            win[IX_SWINT]: begin
                pick.vector = sw_vec(ev);
                pick.cls = CL_TRAP;
            end
            win[IX_NEXT_DBG]: begin
                pick.vector = VEC_DEBUG;
                pick.save_ip = cur_ip;
            end
            win[IX_NMI]: begin
                pick.vector = VEC_NMI;
                pick.cls = CL_MASKABLE_REQUEST;
            end
            win[IX_FETCH]: begin
                pick.vector = ev.fetch_vec;
                pick.save_ip = cur_ip;
            end
            win[IX_DECODE]: begin
                pick.vector = VEC_INVALID;
                pick.save_ip = cur_ip;
            end
            win[IX_DNA_WAIT], win[IX_DNA_ESC]: begin
                pick.vector = VEC_DNA;
                pick.save_ip = cur_ip;
            end
            win[IX_FPU]: begin
                pick.vector = VEC_FPU;
                pick.save_ip = cur_ip;
            end
            win[IX_SEG]: begin
                pick.vector = ev.seg_vec;
                pick.save_ip = cur_ip;
            end
            win[IX_PAGE]: begin
                pick.vector = VEC_PAGE;
                pick.save_ip = cur_ip;
            end
            win[IX_ALIGN]: begin
                pick.vector = VEC_ALIGN;
                pick.save_ip = cur_ip;
            end
            win[IX_EXEC]: begin
                pick.vector = ev.exec_vec;
                pick.save_ip = cur_ip;
            end
            default: begin
                pick.vector = VEC_DIV;
            end
        endcase
        if (pick.cls == CL_FAULT && ev.tss_partial) begin
            pick.restart = 1'b0;
        end
        pick = finish(pick, ctl_q[CTL_PE], base_q, limit_q);
    end

    // ****************************************
    // decision sequencer
    // ****************************************
    // the maskable vector is only known after acknowledge, so that case waits in ST_ACK
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (decide && win[IX_MASKABLE_REQUEST]) begin
                        state_q <= ST_ACK;
                    end else if (decide && |win) begin
                        state_q <= ST_HOLD;
                    end
                end
                ST_ACK: begin
                    if (inta_ack) begin
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign inta_req = state_q == ST_ACK;
    assign busy = state_q != ST_IDLE;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            res_q <= '0;
            win_q <= '0;
        end else if (decide && |win) begin
            res_q <= pick;
            win_q <= win;
            if (win[IX_MASKABLE_REQUEST]) begin
                res_q.cls <= CL_MASKABLE_REQUEST;
            end
        end else if (state_q == ST_ACK && inta_ack) begin
            res_q <= finish('{vector: inta_vector, cls: CL_MASKABLE_REQUEST, restart: 1'b1,
                              push_err: 1'b0, save_ip: res_q.save_ip,
                              save_flags: res_q.save_flags, entry_addr: 32'h0,
                              entry_size: 4'h0, limit_err: 1'b0},
                            ctl_q[CTL_PE], base_q, limit_q);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            res_valid_q <= 1'b0;
        end else begin
            res_valid_q <= (decide && |win && !win[IX_MASKABLE_REQUEST])
                           || (state_q == ST_ACK && inta_ack);
        end
    end

    assign res_valid = res_valid_q;
    assign res = res_q;

    // ****************************************
    // checks
    // ****************************************
    chk_single_result: assert property (@(posedge clock) disable iff (rst)
        res_valid |=> !res_valid) else $error("two results in a row");
    chk_maskable_request_gated: assert property (@(posedge clock) disable iff (rst)
        $rose(inta_req) |-> $past(flags_q[FLAG_IF]) && $past(maskable_request))
        else $error("acknowledge without enable");
    chk_nmi_vector: assert property (@(posedge clock) disable iff (rst)
        res_valid && win_q[IX_NMI] |-> res.vector == VEC_NMI && res.cls == CL_MASKABLE_REQUEST)
        else $error("nonmaskable vector wrong");
    chk_nmi_first: assert property (@(posedge clock) disable iff (rst)
        decide && lvl_req[IX_NMI] && lvl_req[IX_MASKABLE_REQUEST] |=> state_q == ST_HOLD ##1 res.vector == VEC_NMI)
        else $error("maskable beat nonmaskable");
    chk_step_trap: assert property (@(posedge clock) disable iff (rst)
        decide && win[IX_PREV_DBG] |=> res_valid && res.vector == VEC_DEBUG && res.cls == CL_TRAP)
        else $error("single step trap wrong");
    chk_fault_restart: assert property (@(posedge clock) disable iff (rst)
        decide && |win[IX_EXEC:IX_FETCH] && !ev.tss_partial
        |=> res_valid && res.restart && res.save_ip == $past(cur_ip))
        else $error("fault not restartable");
    chk_entry_size: assert property (@(posedge clock) disable iff (rst)
        res_valid && res.cls != CL_SMM |-> res.entry_size == (ctl_q[CTL_PE] ? SIZE_PROT : SIZE_REAL))
        else $error("entry size wrong");
    chk_ack_hold: assert property (@(posedge clock) disable iff (rst)
        inta_req && !inta_ack |=> inta_req) else $error("acknowledge dropped");
    chk_nmi_write: assert property (@(posedge clock) disable iff (rst)
        config_ctrl_seven_nmi_wr |=> nmi_pend_q) else $error("nonmaskable not pending");
    chk_table_reset: assert property (@(posedge clock) disable iff (rst)
        $past(rst) |-> base_q == BASE_RST && limit_q == LIMIT_RST)
        else $error("table pointer reset wrong");
    cov_maskable_request_ack: cover property (@(posedge clock) disable iff (rst) inta_req ##1 inta_ack);
    cov_nmi: cover property (@(posedge clock) disable iff (rst) res_valid && res.vector == VEC_NMI);
    cov_abort: cover property (@(posedge clock) disable iff (rst) res_valid && res.cls == CL_ABORT);
endmodule // epv_exception_unit
`default_nettype wire

// ===== hdl/epv_pkg.sv
// Notes on behaviour
// - traps are reported only after the causing instruction has completed.
// - a vector call opcode reaches handler n whatever the interrupt enable flag.
// - the breakpoint opcode is a software interrupt through vector 3.
// - with the single step flag set, vector 1 follows every executed instruction.
// - an access matching any of four debug addresses raises vector 1.
// - faults are reported before completion; saved pointer addresses the faulting instruction.
// - vector 1 is a fault, except data breakpoint and single step traps.
// - double fault on vector 8 is the only abort; no restart follows.
// - servicing saves pointer and flags, plus error code for some protected exceptions.
// - 256 vectors; lowest 32 predefined; software calls may use any up to 255.
// - nonmaskable interrupt uses vector 2; any illegal opcode raises vector 6.
// - writing one to bit 2 of config register EBh raises a nonmaskable interrupt.
// - accepting a maskable interrupt runs acknowledge cycles to fetch its vector.
// - table entries are 4 bytes in real mode, 8 bytes in protected mode.
// - after reset the table pointer holds base 00000000h and limit 3FFh.
// - interrupt gate entry clears the interrupt enable flag; trap gates keep it.
// - order: reset, management, previous debug, next debug, nonmaskable, maskable.
// - nonmaskable beats maskable when both arrive at one boundary.
// - maskable interrupt accepted only with request asserted and enable flag one.
// - then fetch, decode, device absent, float error, segment, page, alignment.
// - device absent: wait with switched and monitor; escape with emulation or switched.
// - float error raised for unmasked float exception only with error reporting one.
// - each attempt to execute an instruction yields at most one exception.
// - every fault is restartable except a switch into a partly absent task block.
// - acknowledge reads one 8-bit vector driven by the interrupt controller.
package epv_pkg;
    localparam logic [7:0] VEC_DIV = 8'h00;
    localparam logic [7:0] VEC_DEBUG = 8'h01;
    localparam logic [7:0] VEC_NMI = 8'h02;
    localparam logic [7:0] VEC_BRK = 8'h03;
    localparam logic [7:0] VEC_DNA = 8'h07;
    localparam logic [7:0] VEC_DOUBLE = 8'h08;
    localparam logic [7:0] VEC_INVALID = 8'h06;
    localparam logic [7:0] VEC_PAGE = 8'h0E;
    localparam logic [7:0] VEC_FPU = 8'h10;
    localparam logic [7:0] VEC_ALIGN = 8'h11;
    localparam int FLAG_TF = 8;
    localparam int FLAG_IF = 9;
    localparam int CONFIG_CTRL_SEVEN_NMI_BIT = 2;
    localparam int CTL_TS = 0;
    localparam int CTL_MP = 1;
    localparam int CTL_EM = 2;
    localparam int CTL_NE = 3;
    localparam int CTL_PE = 4;
    localparam logic [7:0] CONFIG_CTRL_SEVEN_IDX = 8'hEB;
    localparam logic [11:0] OFS_FLAGS = 12'h000;
    localparam logic [11:0] OFS_CTL = 12'h004;
    localparam logic [11:0] OFS_BASE = 12'h008;
    localparam logic [11:0] OFS_LIMIT = 12'h00C;
    localparam logic [11:0] OFS_DBG0 = 12'h010;
    localparam logic [11:0] OFS_STATUS = 12'h020;
    localparam logic [11:0] OFS_CONFIG_CTRL_SEVEN = {2'h0, CONFIG_CTRL_SEVEN_IDX, 2'h0};
    localparam logic [31:0] FLAGS_RST = 32'h00000002;
    localparam logic [31:0] BASE_RST = 32'h00000000;
    localparam logic [15:0] LIMIT_RST = 16'h03FF;
    localparam logic [3:0] SIZE_REAL = 4'h4;
    localparam logic [3:0] SIZE_PROT = 4'h8;
    localparam int NLVL = 16;
    typedef enum logic [2:0] {
        CL_TRAP = 3'h0, CL_FAULT = 3'h1, CL_ABORT = 3'h2,
        CL_MASKABLE_REQUEST = 3'h3, CL_SMM = 3'h4
    } epv_class_t;
    typedef struct packed {
        logic instr_done; logic swint; logic [7:0] swint_vec;
        logic brk_op; logic ovf_trap; logic instr_bp;
        logic fetch_fault; logic [7:0] fetch_vec; logic decode_fault;
        logic is_wait; logic is_esc; logic fpu_unmasked;
        logic seg_fault; logic [7:0] seg_vec; logic page_fault;
        logic align_fault; logic exec_fault; logic [7:0] exec_vec;
        logic deliver_fault; logic tss_partial;
    } epv_event_t;
    typedef struct packed {
        logic [7:0] vector; epv_class_t cls; logic restart;
        logic push_err; logic [31:0] save_ip; logic [31:0] save_flags;
        logic [31:0] entry_addr; logic [3:0] entry_size; logic limit_err;
    } epv_result_t;
endpackage

// ===== hdl/epv_dbg_match.sv
`timescale 1ns/1ps
`default_nettype none
module epv_dbg_match #(
    parameter int NREG = 4
) (
    input wire logic [NREG*32-1:0] addr_regs,
    input wire logic acc_valid,
    input wire logic [31:0] acc_addr,
    output logic hit
);
    logic [NREG-1:0] m;
    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : g_cmp
            assign m[g] = acc_valid && (acc_addr == addr_regs[g*32 +: 32]);
        end
    endgenerate
    assign hit = |m;
endmodule // epv_dbg_match
`default_nettype wire

// ===== hdl/epv_prio_pick.sv
`timescale 1ns/1ps
`default_nettype none
module epv_prio_pick #(
    parameter int N = 16
) (
    input wire logic [N-1:0] req,
    output logic [N-1:0] grant
);
    // lowest index wins; at most one grant keeps one exception per attempt
    always_comb begin
        grant = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                grant = '0;
                grant[i] = 1'b1;
            end
        end
    end
endmodule // epv_prio_pick
`default_nettype wire

// ===== verif/epv_intc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// acknowledge answer, three wait cycles
// ****
module epv_intc_model #(parameter logic [7:0] VEC = 8'h41) (
    input wire logic clock,
    input wire logic inta_req,
    output logic inta_ack,
    output logic [7:0] inta_vector
);
    logic [1:0] cnt_q;
    logic go;
    assign go = inta_req && !inta_ack && cnt_q == 2'h2;
    initial inta_ack = 1'b0;
    initial inta_vector = 8'h00;
    initial cnt_q = 2'h0;
    always @(posedge clock) begin
        cnt_q <= (inta_req && !inta_ack) ? cnt_q + 2'h1 : 2'h0;
        inta_ack <= go;
        // released bus shows junk so a stale vector cannot pass
        inta_vector <= go ? VEC : ~inta_vector;
    end
endmodule // epv_intc_model
`default_nettype wire

// ===== verif/exception_priority_vectoring_tb.sv
`timescale 1ns/1ps
`default_nettype none
module exception_priority_vectoring_tb;
    import epv_pkg::*;
    logic clock, rst, read, write, waitrequest, boundary, acc_valid, mreq, inta_req, inta_ack;
    logic h_enter, h_ret, h_gate, smi, busy, res_valid;
    logic [11:0] address;
    logic [31:0] writedata, readdata, rd, acc_addr;
    logic [7:0] inta_vector;
    epv_event_t ev;
    epv_result_t res;
    int miscompares = 0;
    int total_checks = 0;
    epv_exception_unit i_dut (.clock(clock), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .boundary(boundary),
        .ev(ev), .cur_ip(32'h00001000), .next_ip(32'h00001004), .acc_valid(acc_valid),
        .acc_addr(acc_addr), .mgmt_mode_request(smi), .maskable_request(mreq), .inta_req(inta_req),
        .inta_ack(inta_ack), .inta_vector(inta_vector), .handler_enter(h_enter), .gate_is_maskable_request(h_gate),
        .handler_return(h_ret), .busy(busy), .res_valid(res_valid), .res(res));
    epv_intc_model i_intc (.clock(clock), .inta_req(inta_req), .inta_ack(inta_ack),
        .inta_vector(inta_vector));
    // ****
    // tasks
    // ****
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do @(posedge clock); while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic decide(input logic [7:0] v);
        int n;
        n = 0;
        boundary <= 1'b1;
        @(posedge clock);
        boundary <= 1'b0;
        do begin
            @(posedge clock);
            n++;
        end while (res_valid !== 1'b1 && n < 40);
        chk("valid", 1, res_valid); chk("busy", 1, busy);
        chk("vector", {24'h0, v}, {24'h0, res.vector});
        ev <= '0;
        @(posedge clock);
    endtask
    task automatic pulse(input logic ret, input logic gate);
        h_ret <= ret;
        h_enter <= !ret;
        h_gate <= gate;
        @(posedge clock);
        h_ret <= 1'b0;
        h_enter <= 1'b0;
        @(posedge clock);
    endtask
    task automatic end_of_test();
        if (miscompares == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        #100us;
        miscompares++;
        end_of_test();
    end
    initial begin
        {rst, read, write, boundary, acc_valid, mreq, h_enter, h_ret, h_gate, smi} = 10'h200;
        {address, writedata, acc_addr} = '0;
        ev = '0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        bus(0, OFS_BASE, 0); chk("base", BASE_RST, rd);
        bus(0, OFS_LIMIT, 0); chk("limit", {16'h0, LIMIT_RST}, rd);
        bus(0, 12'h7F0, 0); chk("unmapped", 32'h0, rd);
        ev.instr_done <= 1; ev.brk_op <= 1; decide(VEC_BRK); chk("cls", CL_TRAP, res.cls);
        chk("size", SIZE_REAL, res.entry_size);
        ev.instr_done <= 1; ev.swint <= 1; ev.swint_vec <= 8'hFF; decide(8'hFF);
        ev.decode_fault <= 1; ev.page_fault <= 1; decide(VEC_INVALID);
        chk("ip", 32'h1000, res.save_ip); chk("restart", 1, res.restart);
        ev.deliver_fault <= 1; decide(VEC_DOUBLE); chk("restart", 0, res.restart);
        smi <= 1; ev.deliver_fault <= 1; decide(8'h00); chk("cls", CL_SMM, res.cls);
        smi <= 0;
        bus(1, OFS_CTL, 32'h3); ev.is_wait <= 1; decide(VEC_DNA);
        ev.fpu_unmasked <= 1; ev.page_fault <= 1; decide(VEC_PAGE);
        bus(1, OFS_CTL, 32'h18); ev.fpu_unmasked <= 1; ev.page_fault <= 1; decide(VEC_FPU);
        chk("size", SIZE_PROT, res.entry_size); chk("entry", 32'h80, res.entry_addr);
        bus(1, OFS_DBG0, 32'hA0); acc_addr <= 32'hA0; acc_valid <= 1; @(posedge clock); acc_valid <= 0;
        ev.instr_done <= 1; decide(VEC_DEBUG); chk("cls", CL_TRAP, res.cls);
        bus(1, OFS_FLAGS, 32'h302); ev.instr_done <= 1; decide(VEC_DEBUG);
        chk("flags", 32'h302, res.save_flags);
        bus(1, OFS_FLAGS, 32'h202); mreq <= 1; bus(1, OFS_CONFIG_CTRL_SEVEN, 32'h4); decide(VEC_NMI);
        pulse(1, 0);
        decide(8'h41); chk("cls", CL_MASKABLE_REQUEST, res.cls);
        chk("inta", 0, inta_req);
        pulse(0, 0); bus(0, OFS_FLAGS, 0); chk("if", 32'h202, rd);
        pulse(0, 1); bus(0, OFS_FLAGS, 0); chk("if", 32'h002, rd);
        ev.decode_fault <= 1; decide(VEC_INVALID);
        end_of_test();
    end
endmodule // exception_priority_vectoring_tb
`default_nettype wire
